/* pwmgc_top.sv */
// pwm unit: interrupt status, fault status and generator 0 with its controls
// Functional notes
// - raw fault bit 16 latches fault regardless enable
// - raw bit 0 mirrors generator interrupt
// - write one to masked bit 16 clears
// - masked generator bit read-only; clear at source
// - status bit 0 shows live fault level
// - comparator A update: at zero or sync-gated
// - comparator B update selected likewise by bit 5
// - load update: at zero or sync-gated
// - debug halts counter at zero unless bit2
// - mode 0 counts down, reloads load value
// - mode 1 counts up then down
// - enable bit 0 stops or runs generator
// - reserved bits read zero; software preserves them
// - fault interrupt latched until software clears
// - global sync applies queued updates, self-clears
// - module interrupt gated by bits 16, 0
`include "pwmgc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pwmgc_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [11:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   input wire logic fault_in,
   input wire logic debug_in,
   output logic pwm_out_a,
   output logic pwm_out_b,
   output logic irq
);
   pwmgc_gen_if gen ();

   logic gsync_q;
   logic [1:0] out_en_q;
   logic [1:0] invert_q;
   logic [1:0] fault_low_q;
   logic fault_ien_q;
   logic gen_ien_top_q;
   logic fault_ris_q;
   logic [`PWMGC_CTL_W-1:0] ctl_q;
   logic [`PWMGC_EV_W-1:0] gen_ien_q;
   logic [`PWMGC_EV_W-1:0] gen_ris_q;
   logic pair_q;
   logic [`PWMGC_DB_W-1:0] db_rise_q;
   logic [`PWMGC_DB_W-1:0] db_fall_q;
   logic [31:0] rd_data_q;
   logic irq_q;
   logic pwm_a_q;
   logic pwm_b_q;

   logic wr_master;
   logic wr_isc;
   logic wr_gen_isc;
   logic wr_load;
   logic wr_cmpa;
   logic wr_cmpb;
   logic gen0_irq;
   logic [31:0] raw_word;
   logic [31:0] masked_word;
   logic [31:0] rd_mux;
   pwmgc_pkg::pwmgc_cnt_t load_act;
   pwmgc_pkg::pwmgc_cnt_t cmpa_act;
   pwmgc_pkg::pwmgc_cnt_t cmpb_act;
   logic load_pend;
   logic cmpa_pend;
   logic cmpb_pend;
   logic [`PWMGC_EV_W-1:0] gen_ev;
   logic src_a;
   logic src_b;
   logic [1:0] db_in;
   logic [1:0] db_out;
   logic [`PWMGC_DB_W-1:0] db_delay [2];
   logic [1:0] shaped;
   logic [1:0] pin_val;

   assign wr_master = wr_en && (addr == `PWMGC_OFF_MASTER);
   assign wr_isc = wr_en && (addr == `PWMGC_OFF_ISC);
   assign wr_gen_isc = wr_en && (addr == `PWMGC_OFF_GEN_ISC);
   assign wr_load = wr_en && (addr == `PWMGC_OFF_LOAD);
   assign wr_cmpa = wr_en && (addr == `PWMGC_OFF_CMPA);
   assign wr_cmpb = wr_en && (addr == `PWMGC_OFF_CMPB);

   // writes to unmapped or read-only offsets match no branch and are dropped
   // control registers written by software
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         out_en_q <= 2'h0;
         invert_q <= 2'h0;
         fault_low_q <= 2'h0;
         fault_ien_q <= 1'b0;
         gen_ien_top_q <= 1'b0;
         ctl_q <= `PWMGC_RST_CTL;
         gen_ien_q <= `PWMGC_RST_EV;
         pair_q <= 1'b0;
         db_rise_q <= `PWMGC_RST_DB;
         db_fall_q <= `PWMGC_RST_DB;
      end else if (wr_en) begin
         if (addr == `PWMGC_OFF_OUT_EN) begin
            out_en_q <= wr_data[1:0];
         end else if (addr == `PWMGC_OFF_INVERT) begin
            invert_q <= wr_data[1:0];
         end else if (addr == `PWMGC_OFF_FAULT_LOW) begin
            fault_low_q <= wr_data[1:0];
         end else if (addr == `PWMGC_OFF_IRQ_EN) begin
            fault_ien_q <= wr_data[`PWMGC_BIT_FAULT];
            gen_ien_top_q <= wr_data[`PWMGC_BIT_GEN0];
         end else if (addr == `PWMGC_OFF_GEN_CTL) begin
            ctl_q <= wr_data[`PWMGC_CTL_W-1:0];
         end else if (addr == `PWMGC_OFF_GEN_IEN) begin
            gen_ien_q <= wr_data[`PWMGC_EV_W-1:0];
         end else if (addr == `PWMGC_OFF_DB_CTL) begin
            pair_q <= wr_data[`PWMGC_BIT_PAIR];
         end else if (addr == `PWMGC_OFF_DB_RISE) begin
            db_rise_q <= wr_data[`PWMGC_DB_W-1:0];
         end else if (addr == `PWMGC_OFF_DB_FALL) begin
            db_fall_q <= wr_data[`PWMGC_DB_W-1:0];
         end
      end
   end

   // global sync request: set by software, cleared by hardware at the next zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gsync_q <= 1'b0;
      end else if (wr_master && wr_data[`PWMGC_BIT_SYNC]) begin
         gsync_q <= 1'b1;
      end else if (gen.zero_evt) begin
         gsync_q <= 1'b0;
      end
   end

   // zero events are gated by enable, so staged values wait while disabled
   // a second write before the zero replaces the staged value outright
   // counter and the three deferred-update registers
   assign gen.enable = ctl_q[`PWMGC_CTL_EN];
   assign gen.mode = ctl_q[`PWMGC_CTL_MODE];
   assign gen.dbg_run = ctl_q[`PWMGC_CTL_DBG];
   assign gen.debug_in = debug_in;
   assign gen.load = load_act;

   pwmgc_counter u_counter (
      .clk(clk),
      .sys_rst(sys_rst),
      .g(gen)
   );

   pwmgc_shadow #(.W(`PWMGC_CNT_W)) u_load (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_load),
      .wr_val(wr_data[`PWMGC_CNT_W-1:0]),
      .sync_mode(ctl_q[`PWMGC_CTL_LDUPD]),
      .gsync(gsync_q),
      .zero_evt(gen.zero_evt),
      .active(load_act),
      .pending(load_pend)
   );

   pwmgc_shadow #(.W(`PWMGC_CNT_W)) u_cmpa (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_cmpa),
      .wr_val(wr_data[`PWMGC_CNT_W-1:0]),
      .sync_mode(ctl_q[`PWMGC_CTL_CAUPD]),
      .gsync(gsync_q),
      .zero_evt(gen.zero_evt),
      .active(cmpa_act),
      .pending(cmpa_pend)
   );

   pwmgc_shadow #(.W(`PWMGC_CNT_W)) u_cmpb (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr(wr_cmpb),
      .wr_val(wr_data[`PWMGC_CNT_W-1:0]),
      .sync_mode(ctl_q[`PWMGC_CTL_CBUPD]),
      .gsync(gsync_q),
      .zero_evt(gen.zero_evt),
      .active(cmpb_act),
      .pending(cmpb_pend)
   );

   // generator events and their sticky status, set wins over clear
   always_comb begin
      gen_ev = '0;
      gen_ev[`PWMGC_EV_ZERO] = gen.zero_evt;
      gen_ev[`PWMGC_EV_LOAD] = gen.enable && (gen.count == load_act);
      gen_ev[`PWMGC_EV_CAU] = gen.enable && (gen.count == cmpa_act)
         && (gen.dir == pwmgc_pkg::PWMGC_UP);
      gen_ev[`PWMGC_EV_CAD] = gen.enable && (gen.count == cmpa_act)
         && (gen.dir == pwmgc_pkg::PWMGC_DOWN);
      gen_ev[`PWMGC_EV_CBU] = gen.enable && (gen.count == cmpb_act)
         && (gen.dir == pwmgc_pkg::PWMGC_UP);
      gen_ev[`PWMGC_EV_CBD] = gen.enable && (gen.count == cmpb_act)
         && (gen.dir == pwmgc_pkg::PWMGC_DOWN);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gen_ris_q <= `PWMGC_RST_EV;
      end else begin
         gen_ris_q <= (gen_ris_q & ~(wr_gen_isc ? wr_data[`PWMGC_EV_W-1:0] : '0)) | gen_ev;
      end
   end

   assign gen0_irq = |(gen_ris_q & gen_ien_q);

   // fault_in is taken as synchronous; a pulse between two edges is missed
   // fault latch: held until a one is written to the masked status bit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_ris_q <= 1'b0;
      end else if (fault_in) begin
         fault_ris_q <= 1'b1;
      end else if (wr_isc && wr_data[`PWMGC_BIT_FAULT]) begin
         fault_ris_q <= 1'b0;
      end
   end

   always_comb begin
      raw_word = 32'h0000_0000;
      raw_word[`PWMGC_BIT_FAULT] = fault_ris_q;
      raw_word[`PWMGC_BIT_GEN0] = gen0_irq;
      masked_word = 32'h0000_0000;
      masked_word[`PWMGC_BIT_FAULT] = fault_ris_q && fault_ien_q;
      masked_word[`PWMGC_BIT_GEN0] = gen0_irq && gen_ien_top_q;
   end

   // irq is registered, so it trails the masked bits by one cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |masked_word;
      end
   end

   // pwm shaping: independent compares or a dead-band complementary pair
   // each paired leg rises after its own delay and falls at once, so they never overlap
   assign src_a = gen.enable && (gen.count < cmpa_act);
   assign src_b = gen.enable && (gen.count < cmpb_act);
   assign db_in[0] = src_a;
   assign db_in[1] = gen.enable && !src_a;
   assign db_delay[0] = db_rise_q;
   assign db_delay[1] = db_fall_q;

   for (genvar i = 0; i < 2; i++) begin : g_db
      logic [`PWMGC_DB_W-1:0] wait_q;
      logic on_q;
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            wait_q <= `PWMGC_RST_DB;
            on_q <= 1'b0;
         end else if (!db_in[i]) begin
            wait_q <= `PWMGC_RST_DB;
            on_q <= 1'b0;
         end else if (wait_q >= db_delay[i]) begin
            on_q <= 1'b1;
         end else begin
            wait_q <= `PWMGC_DB_W'(wait_q + 1'b1);
         end
      end
      assign db_out[i] = on_q;
   end

   assign shaped = pair_q ? db_out : {src_b, src_a};
   // fault forcing acts before the enable gate and the inverter
   assign pin_val = ((shaped & ~({2{fault_in}} & fault_low_q)) & out_en_q) ^ invert_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pwm_a_q <= 1'b0;
         pwm_b_q <= 1'b0;
      end else begin
         pwm_a_q <= pin_val[0];
         pwm_b_q <= pin_val[1];
      end
   end

   // register read, data valid in the cycle after the strobe only
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (addr == `PWMGC_OFF_MASTER) begin
         rd_mux[`PWMGC_BIT_SYNC] = gsync_q;
      end else if (addr == `PWMGC_OFF_OUT_EN) begin
         rd_mux[1:0] = out_en_q;
      end else if (addr == `PWMGC_OFF_INVERT) begin
         rd_mux[1:0] = invert_q;
      end else if (addr == `PWMGC_OFF_FAULT_LOW) begin
         rd_mux[1:0] = fault_low_q;
      end else if (addr == `PWMGC_OFF_IRQ_EN) begin
         rd_mux[`PWMGC_BIT_FAULT] = fault_ien_q;
         rd_mux[`PWMGC_BIT_GEN0] = gen_ien_top_q;
      end else if (addr == `PWMGC_OFF_RAW) begin
         rd_mux = raw_word;
      end else if (addr == `PWMGC_OFF_ISC) begin
         rd_mux = masked_word;
      end else if (addr == `PWMGC_OFF_STATUS) begin
         rd_mux[`PWMGC_BIT_LEVEL] = fault_in;
      end else if (addr == `PWMGC_OFF_GEN_CTL) begin
         rd_mux[`PWMGC_CTL_W-1:0] = ctl_q;
      end else if (addr == `PWMGC_OFF_GEN_IEN) begin
         rd_mux[`PWMGC_EV_W-1:0] = gen_ien_q;
      end else if (addr == `PWMGC_OFF_GEN_RIS) begin
         rd_mux[`PWMGC_EV_W-1:0] = gen_ris_q;
      end else if (addr == `PWMGC_OFF_GEN_ISC) begin
         rd_mux[`PWMGC_EV_W-1:0] = gen_ris_q & gen_ien_q;
      end else if (addr == `PWMGC_OFF_LOAD) begin
         rd_mux[`PWMGC_CNT_W-1:0] = load_act;
         rd_mux[31] = load_pend;
      end else if (addr == `PWMGC_OFF_CMPA) begin
         rd_mux[`PWMGC_CNT_W-1:0] = cmpa_act;
         rd_mux[31] = cmpa_pend;
      end else if (addr == `PWMGC_OFF_CMPB) begin
         rd_mux[`PWMGC_CNT_W-1:0] = cmpb_act;
         rd_mux[31] = cmpb_pend;
      end else if (addr == `PWMGC_OFF_DB_CTL) begin
         rd_mux[`PWMGC_BIT_PAIR] = pair_q;
      end else if (addr == `PWMGC_OFF_DB_RISE) begin
         rd_mux[`PWMGC_DB_W-1:0] = db_rise_q;
      end else if (addr == `PWMGC_OFF_DB_FALL) begin
         rd_mux[`PWMGC_DB_W-1:0] = db_fall_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_data_q <= 32'h0000_0000;
      end else begin
         rd_data_q <= rd_en ? rd_mux : 32'h0000_0000;
      end
   end

   assign rd_data = rd_data_q;
   assign irq = irq_q;
   assign pwm_out_a = pwm_a_q;
   assign pwm_out_b = pwm_b_q;
endmodule
`default_nettype wire

/* pwmgc_regs.svh */
// register offsets, field positions and reset values of the pwm generator block
`ifndef PWMGC_REGS_SVH
`define PWMGC_REGS_SVH
`define PWMGC_ADDR_W 12
`define PWMGC_OFF_MASTER 12'h000
`define PWMGC_OFF_OUT_EN 12'h008
`define PWMGC_OFF_INVERT 12'h00c
`define PWMGC_OFF_FAULT_LOW 12'h010
`define PWMGC_OFF_IRQ_EN 12'h014
`define PWMGC_OFF_RAW 12'h018
`define PWMGC_OFF_ISC 12'h01c
`define PWMGC_OFF_STATUS 12'h020
`define PWMGC_OFF_GEN_CTL 12'h040
`define PWMGC_OFF_GEN_IEN 12'h044
`define PWMGC_OFF_GEN_RIS 12'h048
`define PWMGC_OFF_GEN_ISC 12'h04c
`define PWMGC_OFF_LOAD 12'h050
`define PWMGC_OFF_CMPA 12'h058
`define PWMGC_OFF_CMPB 12'h05c
`define PWMGC_OFF_DB_CTL 12'h060
`define PWMGC_OFF_DB_RISE 12'h064
`define PWMGC_OFF_DB_FALL 12'h068
`define PWMGC_BIT_FAULT 16
`define PWMGC_BIT_GEN0 0
`define PWMGC_BIT_SYNC 0
`define PWMGC_BIT_LEVEL 0
`define PWMGC_BIT_PAIR 0
`define PWMGC_CTL_EN 0
`define PWMGC_CTL_MODE 1
`define PWMGC_CTL_DBG 2
`define PWMGC_CTL_LDUPD 3
`define PWMGC_CTL_CAUPD 4
`define PWMGC_CTL_CBUPD 5
`define PWMGC_CTL_W 6
`define PWMGC_EV_ZERO 0
`define PWMGC_EV_LOAD 1
`define PWMGC_EV_CAU 2
`define PWMGC_EV_CAD 3
`define PWMGC_EV_CBU 4
`define PWMGC_EV_CBD 5
`define PWMGC_EV_W 6
`define PWMGC_CNT_W 16
`define PWMGC_DB_W 12
`define PWMGC_RST_CTL 6'h00
`define PWMGC_RST_CNT 16'h0000
`define PWMGC_RST_DB 12'h000
`define PWMGC_RST_EV 6'h00
`endif

/* pwmgc_pkg.sv */
// shared types of the pwm generator block
package pwmgc_pkg;
   typedef logic [15:0] pwmgc_cnt_t;
   typedef enum logic {PWMGC_DOWN, PWMGC_UP} pwmgc_dir_e;
endpackage

/* pwmgc_gen_if.sv */
// link between the register core and the generator counter
`timescale 1ns/1ps
`default_nettype none
interface pwmgc_gen_if;
   logic enable;
   logic mode;
   logic dbg_run;
   logic debug_in;
   pwmgc_pkg::pwmgc_cnt_t load;
   pwmgc_pkg::pwmgc_cnt_t count;
   pwmgc_pkg::pwmgc_dir_e dir;
   logic zero_evt;
   modport ctr (input enable, mode, dbg_run, debug_in, load, output count, dir, zero_evt);
   modport core (output enable, mode, dbg_run, debug_in, load, input count, dir, zero_evt);
endinterface
`default_nettype wire

/* pwmgc_shadow.sv */
// staged value with deferred application at counter zero
`timescale 1ns/1ps
`default_nettype none
module pwmgc_shadow #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wr,
   input wire logic [W-1:0] wr_val,
   input wire logic sync_mode,
   input wire logic gsync,
   input wire logic zero_evt,
   output logic [W-1:0] active,
   output logic pending
);
   logic [W-1:0] staged_q;
   logic [W-1:0] active_q;
   logic pend_q;
   logic apply;

   assign apply = pend_q && zero_evt && (!sync_mode || gsync);
   assign active = active_q;
   assign pending = pend_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         staged_q <= '0;
         pend_q <= 1'b0;
      end else if (wr) begin
         staged_q <= wr_val;
         pend_q <= 1'b1;
      end else if (apply) begin
         pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         active_q <= '0;
      end else if (apply) begin
         active_q <= staged_q;
      end
   end
endmodule
`default_nettype wire

/* pwmgc_counter.sv */
// generator counter: count-down or up/down, with debug halt at zero
`timescale 1ns/1ps
`default_nettype none
module pwmgc_counter (
   input wire logic clk,
   input wire logic sys_rst,
   pwmgc_gen_if.ctr g
);
   pwmgc_pkg::pwmgc_cnt_t count_q;
   pwmgc_pkg::pwmgc_dir_e dir_q;
   logic halt;

   assign halt = g.debug_in && !g.dbg_run && (count_q == '0);
   assign g.count = count_q;
   assign g.dir = dir_q;
   assign g.zero_evt = g.enable && (count_q == '0);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_q <= '0;
         dir_q <= pwmgc_pkg::PWMGC_DOWN;
      end else if (!g.enable) begin
         count_q <= '0;
         dir_q <= g.mode ? pwmgc_pkg::PWMGC_UP : pwmgc_pkg::PWMGC_DOWN;
      end else if (!halt) begin
         case (g.mode)
            1'b0: begin
               dir_q <= pwmgc_pkg::PWMGC_DOWN;
               if (count_q == '0) begin
                  count_q <= g.load;
               end else begin
                  count_q <= 16'(count_q - 16'h0001);
               end
            end
            default: begin
               if (dir_q == pwmgc_pkg::PWMGC_UP) begin
                  if (count_q >= g.load) begin
                     dir_q <= pwmgc_pkg::PWMGC_DOWN;
                     count_q <= (count_q == '0) ? '0 : 16'(count_q - 16'h0001);
                  end else begin
                     count_q <= 16'(count_q + 16'h0001);
                  end
               end else if (count_q == '0) begin
                  dir_q <= pwmgc_pkg::PWMGC_UP;
                  count_q <= (g.load == '0) ? '0 : 16'h0001;
               end else begin
                  count_q <= 16'(count_q - 16'h0001);
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* pwmgc_top_properties.sv */
// port-level assertions for the pwm unit top
`include "pwmgc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pwmgc_top_properties (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [11:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rd_data,
   input wire logic fault_in,
   input wire logic debug_in,
   input wire logic pwm_out_a,
   input wire logic pwm_out_b,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   logic rd_raw, rd_isc, rd_sts, rd_ctl, wr_isc, wr_ctl;
   assign rd_raw = rd_en && addr == `PWMGC_OFF_RAW;
   assign rd_isc = rd_en && addr == `PWMGC_OFF_ISC;
   assign rd_sts = rd_en && addr == `PWMGC_OFF_STATUS;
   assign rd_ctl = rd_en && addr == `PWMGC_OFF_GEN_CTL;
   assign wr_isc = wr_en && addr == `PWMGC_OFF_ISC;
   assign wr_ctl = wr_en && addr == `PWMGC_OFF_GEN_CTL;
   status_live_a: assert property (rd_sts |=> rd_data == {31'h0, $past(fault_in)})
      else $error("fault level read wrong");
   fault_latch_a: assert property (fault_in ##1 rd_raw |=> rd_data[16])
      else $error("fault not latched in raw status");
   w1c_clear_a: assert property ((wr_isc && wr_data[16] && !fault_in) ##1 !fault_in ##1 rd_raw
      |=> !rd_data[16]) else $error("fault latch not cleared");
   w0_keep_a: assert property (rd_raw ##1 (rd_data[16] && !wr_en) ##1
      (wr_isc && !wr_data[16]) ##1 !wr_en ##1 rd_raw |=> rd_data[16])
      else $error("fault latch lost without clear");
   irq_or_a: assert property (rd_isc |=> irq == (|rd_data))
      else $error("irq differs from masked status");
   masked_sub_a: assert property ((rd_raw && !fault_in) ##1 !fault_in ##1 rd_isc
      |=> !rd_data[16] || $past(rd_data[16], 2)) else $error("masked bit without raw bit");
   reserved_zero_a: assert property (rd_raw || rd_isc |=>
      rd_data[31:17] == 15'h0 && rd_data[15:1] == 15'h0) else $error("reserved bits set");
   ctl_readback_a: assert property (wr_ctl ##1 !wr_en ##1 rd_ctl |=>
      rd_data == {26'h0, $past(wr_data[5:0], 3)}) else $error("control readback wrong");
   unmapped_zero_a: assert property (rd_en && addr == 12'h0f0 |=> rd_data == 32'h0)
      else $error("unmapped read not zero");
   cover property (rd_raw ##1 rd_data[16]);
   cover property ($rose(irq));
   cover property (debug_in && pwm_out_a);
endmodule
`default_nettype wire

/* pwmgc_power_stage.sv */
// behavioural power stage: counts the high cycles of both legs
`timescale 1ns/1ps
`default_nettype none
module pwmgc_power_stage (
   input wire logic clk,
   input wire logic clr,
   input wire logic leg_a,
   input wire logic leg_b,
   output logic [15:0] on_a,
   output logic [15:0] on_b
);
   always_ff @(posedge clk) begin
      if (clr) begin
         on_a <= 16'h0000;
         on_b <= 16'h0000;
      end else begin
         on_a <= on_a + 16'(leg_a);
         on_b <= on_b + 16'(leg_b);
      end
   end
endmodule
`default_nettype wire

/* pwmgc_top_test.sv */
// self-checking bench for the pwm unit top
`include "pwmgc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module pwmgc_top_test;
   typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} pwmgc_row_s;
   logic clk, sys_rst, wr_en, rd_en, fault_in, debug_in, pwm_out_a, pwm_out_b, irq, clr;
   logic [11:0] addr;
   logic [31:0] wr_data, rd_data;
   logic [15:0] on_a, on_b;
   int errors = 0;
   int n_tests = 0;
   logic [11:0] offs [3] = '{`PWMGC_OFF_LOAD, `PWMGC_OFF_CMPA, `PWMGC_OFF_CMPB};
   logic [31:0] olds [3] = '{32'h4, 32'h2, 32'h3};
   pwmgc_row_s rows [6] = '{'{`PWMGC_OFF_RAW, 32'hffffffff, 32'h0},
      '{`PWMGC_OFF_ISC, 32'h1, 32'h0}, '{`PWMGC_OFF_STATUS, 32'hffffffff, 32'h0},
      '{`PWMGC_OFF_GEN_CTL, 32'hffffffff, 32'h3f}, '{`PWMGC_OFF_GEN_CTL, 32'h0, 32'h0},
      '{12'h0f0, 32'hffffffff, 32'h0}};
   pwmgc_top dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .fault_in(fault_in), .debug_in(debug_in),
      .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b), .irq(irq));
   pwmgc_power_stage stage (.clk(clk), .clr(clr), .leg_a(pwm_out_a), .leg_b(pwm_out_b),
      .on_a(on_a), .on_b(on_b));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      `CHK(rd_data, e)
   endtask
   // settle, then count high cycles of both legs over n cycles
   task automatic duty(input int n, input logic [15:0] ea, input logic [15:0] eb);
      repeat (30) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) @(posedge clk);
      #1;
      `CHK(on_a, ea)
      `CHK(on_b, eb)
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #(8 * 6000);
      errors++;
      print_verdict();
   end
   initial begin
      sys_rst = 1'b1;
      addr = 12'h000;
      wr_data = 32'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      fault_in = 1'b0;
      debug_in = 1'b0;
      clr = 1'b0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rc(rows[i].a, rows[i].e);
      end
      done("registers");
      @(posedge clk);
      fault_in <= 1'b1;
      rc(`PWMGC_OFF_STATUS, 32'h1);
      rc(`PWMGC_OFF_RAW, 32'h10000);
      @(posedge clk);
      fault_in <= 1'b0;
      rc(`PWMGC_OFF_STATUS, 32'h0);
      `CHK(irq, 1'b0)
      wr(`PWMGC_OFF_IRQ_EN, 32'h10000);
      rc(`PWMGC_OFF_ISC, 32'h10000);
      `CHK(irq, 1'b1)
      rc(`PWMGC_OFF_RAW, 32'h10000);
      wr(`PWMGC_OFF_ISC, 32'h0);
      rc(`PWMGC_OFF_RAW, 32'h10000);
      wr(`PWMGC_OFF_ISC, 32'h10000);
      rc(`PWMGC_OFF_RAW, 32'h0);
      `CHK(irq, 1'b0)
      done("fault");
      wr(`PWMGC_OFF_LOAD, 32'h4);
      wr(`PWMGC_OFF_CMPA, 32'h2);
      wr(`PWMGC_OFF_CMPB, 32'h3);
      wr(`PWMGC_OFF_OUT_EN, 32'h3);
      wr(`PWMGC_OFF_GEN_CTL, 32'h1);
      duty(50, 16'h14, 16'h1e);
      wr(`PWMGC_OFF_GEN_CTL, 32'h3);
      duty(40, 16'h0f, 16'h19);
      done("counting");
      wr(`PWMGC_OFF_GEN_IEN, 32'h1);
      rc(`PWMGC_OFF_RAW, 32'h1);
      rc(`PWMGC_OFF_ISC, 32'h0);
      wr(`PWMGC_OFF_ISC, 32'h1);
      wr(`PWMGC_OFF_IRQ_EN, 32'h1);
      rc(`PWMGC_OFF_ISC, 32'h1);
      wr(`PWMGC_OFF_GEN_CTL, 32'h0);
      wr(`PWMGC_OFF_GEN_ISC, 32'h3f);
      rc(`PWMGC_OFF_RAW, 32'h0);
      done("generator irq");
      wr(`PWMGC_OFF_GEN_CTL, 32'h39);
      foreach (offs[i]) begin
         wr(offs[i], 32'h9);
         rc(offs[i], olds[i] | 32'h80000000);
      end
      wr(`PWMGC_OFF_MASTER, 32'h1);
      repeat (20) @(posedge clk);
      foreach (offs[i]) begin
         rc(offs[i], 32'h9);
      end
      rc(`PWMGC_OFF_MASTER, 32'h0);
      done("sync update");
      wr(`PWMGC_OFF_GEN_CTL, 32'h1);
      @(posedge clk);
      debug_in <= 1'b1;
      duty(20, 16'h14, 16'h14);
      wr(`PWMGC_OFF_GEN_CTL, 32'h5);
      duty(50, 16'h2d, 16'h2d);
      @(posedge clk);
      debug_in <= 1'b0;
      wr(`PWMGC_OFF_GEN_CTL, 32'h0);
      duty(20, 16'h0, 16'h0);
      done("debug and enable");
      wr(`PWMGC_OFF_DB_CTL, 32'h1);
      wr(`PWMGC_OFF_DB_RISE, 32'h2);
      wr(`PWMGC_OFF_DB_FALL, 32'h1);
      wr(`PWMGC_OFF_CMPA, 32'h5);
      wr(`PWMGC_OFF_GEN_CTL, 32'h1);
      duty(50, 16'h0f, 16'h14);
      done("dead band");
      wr(`PWMGC_OFF_GEN_CTL, 32'h1);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      `CHK(pwm_out_a, 1'b0)
      for (int i = 0; i < 4; i++) begin
         rc(rows[i].a, 32'h0);
      end
      done("reset");
      print_verdict();
   end
endmodule
bind pwmgc_top pwmgc_top_properties chk (.clk(clk), .sys_rst(sys_rst), .addr(addr),
   .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .fault_in(fault_in),
   .debug_in(debug_in), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b), .irq(irq));
`default_nettype wire
